// >>> shared/tcc_pkg.sv
// shared constants of the 16-bit capture/compare timer
`default_nettype none
package tcc_pkg;
  localparam int          CW           = 16;
  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_PRESCALE = 8'h04;
  localparam logic [7:0]  OFS_CAPCTL   = 8'h08;
  localparam logic [7:0]  OFS_OUTCTL   = 8'h0c;
  localparam logic [7:0]  OFS_CCA      = 8'h10;
  localparam logic [7:0]  OFS_CCB      = 8'h14;
  localparam logic [7:0]  OFS_COUNTER  = 8'h18;
  localparam logic [7:0]  OFS_STATUS   = 8'h1c;
  // counter mode codes (control bits 1:0)
  localparam logic [1:0]  MODE_STOP    = 2'h0;
  localparam logic [1:0]  MODE_FREE    = 2'h1;
  localparam logic [1:0]  MODE_CLEAR_A = 2'h2;
  localparam logic [1:0]  MODE_EVENT   = 2'h3;
  localparam int          CTRL_SRC     = 2;
  // edge select codes
  localparam logic [1:0]  EDGE_FALL    = 2'h0;
  localparam logic [1:0]  EDGE_RISE    = 2'h1;
  localparam logic [1:0]  EDGE_NONE    = 2'h2;
  localparam logic [1:0]  EDGE_BOTH    = 2'h3;
  localparam int          PRE_EA       = 2;
  localparam int          PRE_EB       = 4;
  localparam int          CAP_A        = 0;
  localparam int          CAP_B        = 1;
  localparam int          CAP_SRC      = 2;
  localparam int          OUT_PIN      = 0;
  localparam int          OUT_INV_A    = 1;
  localparam int          OUT_INV_B    = 2;
  localparam int          OUT_PPG      = 3;
  // prescaler: count clock = clk / 4^k, masks over the divider
  localparam int          DIV_W        = 6;
  localparam logic [5:0]  DIV_MASK0    = 6'h00;
  localparam logic [5:0]  DIV_MASK1    = 6'h03;
  localparam logic [5:0]  DIV_MASK2    = 6'h0f;
  localparam logic [5:0]  DIV_MASK3    = 6'h3f;
  localparam logic [1:0]  ARM_EDGES    = 2'h2;
  typedef enum logic [1:0] {TCC_IDLE, TCC_ACCESS} tcc_apb_e;
endpackage : tcc_pkg
`default_nettype wire

// >>> hw/tcc_timer.sv
// 16-bit timer/event counter with capture, compare and pulse output behind APB
// Notes on behaviour
// - source select set and both A edges chosen: register A never captures.
// - source select set: trigger B edge raises match irq A without capturing.
// - capture at count clock fall, its interrupt at the next rise.
// - a register in compare mode ignores capture triggers.
// - counter keeps counting while inversion and interrupts are disabled.
// - enabling with input high after reset or low-stop gives immediate rising edge.
// - stopped high, enabled after input went low: immediate falling edge.
// - filter samples with clk for count clock, prescaled tick for capture, twice.
// - event counting starts only after two valid edges.
// - pulse period is cycle+1 counts, active for duty+1 counts.
// - shared pin is trigger B input or timer output, never both.
// - sample clock picked by prescale bits 1:0; inputs seen with sampling delay.
// - counter runs only while mode is not stop, and clears when stopped.
`timescale 1ns/100ps
`default_nettype none
module tcc_timer #(
  parameter int W = tcc_pkg::CW
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic              pready,
  output logic [31:0]       prdata,
  output logic              pslverr,
  input  wire logic         trigger_input_a,
  input  wire logic         shared_port_pin_i,
  output logic              shared_port_pin_o,
  output logic              shared_port_pin_oe_n,
  output logic              match_irq_a,
  output logic              match_irq_b
);
  logic [2:0]   ctrl_q, ctrl_d;
  logic [5:0]   pre_q, pre_d;
  logic [2:0]   capc_q, capc_d;
  logic [3:0]   outc_q, outc_d;
  logic [W-1:0] cca_q, cca_d, ccb_q, ccb_d, cnt_q, cnt_d;
  logic [5:0]   div_q, div_d;
  logic [1:0]   smp_q, smp_d, flt_q, flt_d;
  logic [1:0]   arm_q, arm_d;
  logic         pend_a_q, pend_a_d, pend_b_q, pend_b_d;
  logic         out_q, out_d, irqa_q, irqa_d, irqb_q, irqb_d;
  logic [31:0]  rd_q, rd_d;
  logic         err_q, err_d;
  logic         running, pre_tick, ext_clk, wr, hit;
  logic [5:0]   mask;
  logic [1:0]   trig, smp_en, edge_v, rev_a;
  logic         cnt_en, cap_a, cap_b, mat_a, mat_b, irq_a_now, irq_b_now;
  logic [31:0]  rd_val;

  assign running = ctrl_q[1:0] != tcc_pkg::MODE_STOP;
  assign ext_clk = ctrl_q[tcc_pkg::CTRL_SRC] || ctrl_q[1:0] == tcc_pkg::MODE_EVENT;
  // pin direction: input path dead while the pin drives out
  assign trig[0] = trigger_input_a;
  assign trig[1] = shared_port_pin_i & ~outc_q[tcc_pkg::OUT_PIN];

  always_comb begin
    case (pre_q[1:0])
      2'h0:    mask = tcc_pkg::DIV_MASK0;
      2'h1:    mask = tcc_pkg::DIV_MASK1;
      2'h2:    mask = tcc_pkg::DIV_MASK2;
      default: mask = tcc_pkg::DIV_MASK3;
    endcase
  end
  assign pre_tick = &(div_q | ~mask);

  // trigger A as count clock samples every clk; capture inputs use the tick
  assign smp_en[0] = running & (ext_clk | pre_tick);
  assign smp_en[1] = running & pre_tick;

  // filtered level only moves while running; frozen level gives edges
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_flt
      logic [1:0] es;
      assign es = g == 0 ? pre_q[tcc_pkg::PRE_EA +: 2] : pre_q[tcc_pkg::PRE_EB +: 2];
      always_comb begin
        smp_d[g] = smp_q[g];
        flt_d[g] = flt_q[g];
        if (smp_en[g]) begin
          smp_d[g] = trig[g];
          if (trig[g] == smp_q[g]) begin
            flt_d[g] = trig[g];
          end
        end
      end
      // edge of filtered level against the level held at stop or reset
      always_comb begin
        edge_v[g] = 1'b0;
        rev_a[g]  = 1'b0;
        if (flt_d[g] != flt_q[g]) begin
          case (es)
            tcc_pkg::EDGE_RISE: begin
              edge_v[g] = flt_d[g];
              rev_a[g]  = ~flt_d[g];
            end
            tcc_pkg::EDGE_FALL: begin
              edge_v[g] = ~flt_d[g];
              rev_a[g]  = flt_d[g];
            end
            tcc_pkg::EDGE_BOTH: edge_v[g] = 1'b1;
            default:            edge_v[g] = 1'b0;
          endcase
        end
      end
    end
  endgenerate

  assign cnt_en = running & (ext_clk ? edge_v[0] & (ctrl_q[1:0] != tcc_pkg::MODE_EVENT
                  || arm_q == tcc_pkg::ARM_EDGES) : pre_tick);
  assign mat_a = cnt_en & ~capc_q[tcc_pkg::CAP_A] & cnt_q == cca_q;
  assign mat_b = cnt_en & ~capc_q[tcc_pkg::CAP_B] & cnt_q == ccb_q;
  // source select: A is loaded by the opposite A edge, B edges only interrupt
  assign cap_a = running & capc_q[tcc_pkg::CAP_A] & (capc_q[tcc_pkg::CAP_SRC]
                 ? rev_a[0] : edge_v[1]);
  assign cap_b = running & capc_q[tcc_pkg::CAP_B] & edge_v[0];
  // capture lands now (count clock fall); its interrupt waits for the next tick
  assign irq_a_now = mat_a | (pre_tick & pend_a_q);
  assign irq_b_now = mat_b | (pre_tick & pend_b_q);

  assign wr  = psel & penable & pwrite;
  assign hit = paddr[7:5] == 3'h0 && paddr[1:0] == 2'h0;

  always_comb begin
    case (paddr)
      tcc_pkg::OFS_CTRL:     rd_val = {29'h0, ctrl_q};
      tcc_pkg::OFS_PRESCALE: rd_val = {26'h0, pre_q};
      tcc_pkg::OFS_CAPCTL:   rd_val = {29'h0, capc_q};
      tcc_pkg::OFS_OUTCTL:   rd_val = {28'h0, outc_q};
      tcc_pkg::OFS_CCA:      rd_val = {{(32-W){1'b0}}, cca_q};
      tcc_pkg::OFS_CCB:      rd_val = {{(32-W){1'b0}}, ccb_q};
      tcc_pkg::OFS_COUNTER:  rd_val = {{(32-W){1'b0}}, cnt_q};
      tcc_pkg::OFS_STATUS:   rd_val = {27'h0, arm_q, flt_q, out_q};
      default:               rd_val = 32'h0;
    endcase
  end

  always_comb begin
    ctrl_d   = ctrl_q;
    pre_d    = pre_q;
    capc_d   = capc_q;
    outc_d   = outc_q;
    cca_d    = cca_q;
    ccb_d    = ccb_q;
    cnt_d    = cnt_q;
    arm_d    = arm_q;
    pend_a_d = pend_a_q & ~pre_tick;
    pend_b_d = pend_b_q & ~pre_tick;
    out_d    = out_q;
    rd_d     = rd_q;
    err_d    = err_q;
    div_d    = div_q + 6'h1;
    // setup phase latches the answer so read data leaves a flip-flop
    if (psel & ~penable) begin
      rd_d  = pwrite ? 32'h0 : rd_val;
      err_d = ~hit;
    end
    if (!running) begin
      cnt_d = '0;
      arm_d = '0;
    end else begin
      if (ctrl_q[1:0] == tcc_pkg::MODE_EVENT && edge_v[0] && arm_q != tcc_pkg::ARM_EDGES) begin
        arm_d = arm_q + 2'h1;
      end
      // counting never depends on inversion or interrupt state
      if (cnt_en) begin
        cnt_d = (mat_a && ctrl_q[1:0] == tcc_pkg::MODE_CLEAR_A) ? '0 : cnt_q + 1'b1;
      end
    end
    if (cap_a) begin
      cca_d    = cnt_q;
      pend_a_d = 1'b1;
    end
    if (running && capc_q[tcc_pkg::CAP_SRC] && edge_v[1]) begin
      pend_a_d = 1'b1;
    end
    if (cap_b) begin
      ccb_d    = cnt_q;
      pend_b_d = 1'b1;
    end
    // pulse mode: high from wrap through duty match, so duty+1 of cycle+1 counts
    if (outc_q[tcc_pkg::OUT_PPG]) begin
      if (mat_a && outc_q[tcc_pkg::OUT_INV_A]) out_d = 1'b1;
      else if (mat_b && outc_q[tcc_pkg::OUT_INV_B]) out_d = 1'b0;
    end else if ((mat_a && outc_q[tcc_pkg::OUT_INV_A]) != (mat_b && outc_q[tcc_pkg::OUT_INV_B])) begin
      out_d = ~out_q;
    end
    if (wr && hit) begin
      case (paddr)
        tcc_pkg::OFS_CTRL:     ctrl_d = pwdata[2:0];
        tcc_pkg::OFS_PRESCALE: pre_d  = pwdata[5:0];
        tcc_pkg::OFS_CAPCTL:   capc_d = pwdata[2:0];
        tcc_pkg::OFS_OUTCTL:   outc_d = pwdata[3:0];
        // a capture in the same cycle wins over the software write
        tcc_pkg::OFS_CCA:      if (!cap_a) cca_d = pwdata[W-1:0];
        tcc_pkg::OFS_CCB:      if (!cap_b) ccb_d = pwdata[W-1:0];
        default:               ctrl_d = ctrl_q;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q   <= '0;
      pre_q    <= '0;
      capc_q   <= '0;
      outc_q   <= '0;
      cca_q    <= '0;
      ccb_q    <= '0;
      cnt_q    <= '0;
      div_q    <= '0;
      smp_q    <= '0;
      flt_q    <= '0;
      arm_q    <= '0;
      pend_a_q <= 1'b0;
      pend_b_q <= 1'b0;
      out_q    <= 1'b0;
      irqa_q   <= 1'b0;
      irqb_q   <= 1'b0;
      rd_q     <= '0;
      err_q    <= 1'b0;
    end else begin
      ctrl_q   <= ctrl_d;
      pre_q    <= pre_d;
      capc_q   <= capc_d;
      outc_q   <= outc_d;
      cca_q    <= cca_d;
      ccb_q    <= ccb_d;
      cnt_q    <= cnt_d;
      div_q    <= div_d;
      smp_q    <= smp_d;
      flt_q    <= flt_d;
      arm_q    <= arm_d;
      pend_a_q <= pend_a_d;
      pend_b_q <= pend_b_d;
      out_q    <= out_d;
      irqa_q   <= irq_a_now;
      irqb_q   <= irq_b_now;
      rd_q     <= rd_d;
      err_q    <= err_d;
    end
  end

  assign pready               = psel & penable;
  assign prdata               = rd_q;
  assign pslverr              = psel & penable & err_q;
  assign match_irq_a          = irqa_q;
  assign match_irq_b          = irqb_q;
  assign shared_port_pin_o    = out_q;
  assign shared_port_pin_oe_n = ~outc_q[tcc_pkg::OUT_PIN];

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_cca_idle;
    !(wr && paddr == tcc_pkg::OFS_CCA);
  endsequence
  sequence s_cap_b;
    cap_b ##1 1'b1;
  endsequence

  AST_STOP_CLEAR: assert property (!running |=> cnt_q == '0)
    else $error("counter not cleared while stopped");
  AST_COUNT_STEP: assert property (running && cnt_en && !mat_a |=> cnt_q == $past(cnt_q) + 1'b1)
    else $error("counter failed to advance");
  AST_CAP_VALUE: assert property (s_cap_b |-> ccb_q == $past(cnt_q))
    else $error("capture value wrong");
  AST_CAP_IRQ: assert property (cap_b && !pre_tick |=> pend_b_q)
    else $error("capture interrupt not pending");
  AST_BOTH_NOCAP: assert property ((capc_q[tcc_pkg::CAP_SRC] && pre_q[tcc_pkg::PRE_EA +: 2]
    == tcc_pkg::EDGE_BOTH) and s_cca_idle |=> $stable(cca_q))
    else $error("capture A with both edges selected");
  AST_B_IRQ_ONLY: assert property (running && capc_q[tcc_pkg::CAP_SRC] && edge_v[1] && !pre_tick |=> pend_a_q)
    else $error("trigger B did not raise interrupt A");
  AST_PIN_EXCL: assert property (shared_port_pin_oe_n == !outc_q[tcc_pkg::OUT_PIN]
    && (outc_q[tcc_pkg::OUT_PIN] ? !trig[1] : trig[1] == shared_port_pin_i))
    else $error("pin used both ways");
  AST_EVT_ARM: assert property (ctrl_q[1:0] == tcc_pkg::MODE_EVENT && arm_q != tcc_pkg::ARM_EDGES && !wr |=> cnt_q == $past(cnt_q))
    else $error("event count began too early");
  AST_PPG_RISE: assert property (outc_q[tcc_pkg::OUT_PPG] && outc_q[tcc_pkg::OUT_INV_A] && mat_a |=> out_q ##1 out_q || cnt_q != '0)
    else $error("pulse output not set at cycle match");
  AST_FILTER: assert property (smp_en[0] && trig[0] != smp_q[0] |=> $stable(flt_q[0]))
    else $error("filter passed a single sample");
  AST_RETAIN: assert property (!cap_b && !(wr && paddr == tcc_pkg::OFS_CCB) |=> $stable(ccb_q))
    else $error("capture register changed without capture");
endmodule : tcc_timer
`default_nettype wire

// >>> test/tcc_pulse_src.sv
// external pulse sources driving the two trigger inputs
`timescale 1ns/100ps
`default_nettype none
module tcc_pulse_src (
  input  wire logic clk,
  output logic      trig_a,
  output logic      trig_b
);
  // lines idle low as if pulled down, so a released line never shows a stale level
  initial begin
    trig_a = 1'b0;
    trig_b = 1'b0;
  end
  // callers keep hi above two count clocks so the filter sees the level twice
  task automatic pulse(input bit on_b, input int hi);
    @(posedge clk);
    if (on_b) begin
      trig_b <= 1'b1;
    end else begin
      trig_a <= 1'b1;
    end
    repeat (hi) @(posedge clk);
    trig_a <= 1'b0;
    trig_b <= 1'b0;
    repeat (hi) @(posedge clk);
  endtask : pulse
endmodule : tcc_pulse_src
`default_nettype wire

// >>> test/tb_timer16_capture_compare_rules.sv
// self-checking bench for the capture/compare timer
`timescale 1ns/100ps
`default_nettype none
module tb_timer16_capture_compare_rules;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, c0;
  logic        pin_o, pin_oe_n, irq_a, irq_b, trig_a, trig_b;
  wire logic   pin_lvl;
  int          mismatches, checks, irq_cnt, irqb_cnt, n0, h, l;
  // pin level: the timer when it drives, otherwise the source
  assign pin_lvl = pin_oe_n ? trig_b : pin_o;
  tcc_timer tcc_timer_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .trigger_input_a(trig_a), .shared_port_pin_i(pin_lvl),
    .shared_port_pin_o(pin_o), .shared_port_pin_oe_n(pin_oe_n), .match_irq_a(irq_a),
    .match_irq_b(irq_b));
  tcc_pulse_src tcc_pulse_src_i (.clk(clk), .trig_a(trig_a), .trig_b(trig_b));
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    if (irq_a === 1'b1) begin
      irq_cnt <= irq_cnt + 1;
    end
    if (irq_b === 1'b1) begin
      irqb_cnt <= irqb_cnt + 1;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t ns: %s", $time, what);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // no local limit: a hung slave is caught by the watchdog
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, what);
  endtask : rdc
  task automatic wait_pin(input logic v);
    int n;
    n = 0;
    while (pin_o !== v && n < 60) begin
      @(posedge clk);
      n++;
    end
    if (pin_o !== v) begin
      mismatches++;
      $display("wrong value at %0t ns: pulse output stuck", $time);
    end
  endtask : wait_pin
  task automatic shape(input int hi_exp, input int per_exp);
    wait_pin(1'b0);
    wait_pin(1'b1);
    h = 0;
    l = 0;
    while (pin_o === 1'b1 && h < 50) begin
      @(posedge clk);
      h++;
    end
    while (pin_o === 1'b0 && l < 50) begin
      @(posedge clk);
      l++;
    end
    chk(32'(h), 32'(hi_exp), "active share");
    chk(32'(h + l), 32'(per_exp), "pulse period");
  endtask : shape
  task automatic t_reset;
    rdc(tcc_pkg::OFS_CTRL, 32'h0, "control after reset");
    rdc(tcc_pkg::OFS_COUNTER, 32'h0, "counter after reset");
    apb(1'b0, 8'h40, 32'h0);
    chk(32'(err), 32'h1, "unmapped access error");
    $display("test reset done");
  endtask : t_reset
  task automatic t_count;
    // tick every fourth clk; the two reads latch 44 clocks apart, so 11 ticks
    apb(1'b1, tcc_pkg::OFS_PRESCALE, 32'h1);
    apb(1'b1, tcc_pkg::OFS_CTRL, 32'(tcc_pkg::MODE_FREE));
    apb(1'b0, tcc_pkg::OFS_COUNTER, 32'h0);
    c0 = rd;
    repeat (41) @(posedge clk);
    apb(1'b0, tcc_pkg::OFS_COUNTER, 32'h0);
    chk(rd - c0, 32'hb, "counter advances once per tick");
    apb(1'b1, tcc_pkg::OFS_CTRL, 32'(tcc_pkg::MODE_STOP));
    rdc(tcc_pkg::OFS_COUNTER, 32'h0, "stopped counter cleared");
    $display("test count done");
  endtask : t_count
  task automatic t_capture;
    apb(1'b1, tcc_pkg::OFS_PRESCALE, 32'h10);
    apb(1'b1, tcc_pkg::OFS_CAPCTL, 32'h3);
    apb(1'b1, tcc_pkg::OFS_CTRL, 32'(tcc_pkg::MODE_FREE));
    // let the counter run to about 100 so the captured count lands in the checked range
    repeat (100) @(posedge clk);
    n0 = irq_cnt;
    tcc_pulse_src_i.pulse(1'b1, 6);
    chk(32'(irq_cnt - n0), 32'h1, "capture irq");
    apb(1'b0, tcc_pkg::OFS_CCA, 32'h0);
    c0 = rd;
    chk(32'(c0 >= 95 && c0 < 120), 32'h1, "captured count");
    repeat (50) @(posedge clk);
    rdc(tcc_pkg::OFS_CCA, c0, "capture held");
    // falling edge of trigger A loads the second register later in the run
    n0 = irqb_cnt;
    tcc_pulse_src_i.pulse(1'b0, 6);
    chk(32'(irqb_cnt - n0), 32'h1, "second capture irq");
    apb(1'b0, tcc_pkg::OFS_CCB, 32'h0);
    chk(32'(rd > c0), 32'h1, "second register captured");
    $display("test capture done");
  endtask : t_capture
  task automatic t_source;
    apb(1'b1, tcc_pkg::OFS_CTRL, 32'(tcc_pkg::MODE_STOP));
    apb(1'b1, tcc_pkg::OFS_PRESCALE, 32'h1c);
    apb(1'b1, tcc_pkg::OFS_CAPCTL, 32'h5);
    apb(1'b1, tcc_pkg::OFS_CTRL, 32'(tcc_pkg::MODE_FREE));
    repeat (200) @(posedge clk);
    apb(1'b0, tcc_pkg::OFS_CCA, 32'h0);
    c0 = rd;
    tcc_pulse_src_i.pulse(1'b0, 6);
    rdc(tcc_pkg::OFS_CCA, c0, "both edges no capture");
    n0 = irq_cnt;
    tcc_pulse_src_i.pulse(1'b1, 6);
    chk(32'(irq_cnt - n0), 32'h1, "second input irq");
    rdc(tcc_pkg::OFS_CCA, c0, "second input no capture");
    $display("test source done");
  endtask : t_source
  task automatic t_pulse;
    apb(1'b1, tcc_pkg::OFS_CTRL, 32'(tcc_pkg::MODE_STOP));
    apb(1'b1, tcc_pkg::OFS_PRESCALE, 32'h0);
    apb(1'b1, tcc_pkg::OFS_CAPCTL, 32'h0);
    apb(1'b1, tcc_pkg::OFS_CCA, 32'h9);
    apb(1'b1, tcc_pkg::OFS_CCB, 32'h3);
    apb(1'b1, tcc_pkg::OFS_OUTCTL, 32'hf);
    apb(1'b1, tcc_pkg::OFS_CTRL, 32'(tcc_pkg::MODE_CLEAR_A));
    chk(32'(pin_oe_n), 32'h0, "pin driven");
    shape(4, 10);
    // rewrites while counting: inversion off, new value, one count clock, back on
    apb(1'b1, tcc_pkg::OFS_OUTCTL, 32'hd);
    apb(1'b1, tcc_pkg::OFS_CCA, 32'hb);
    @(posedge clk);
    apb(1'b1, tcc_pkg::OFS_OUTCTL, 32'hf);
    apb(1'b1, tcc_pkg::OFS_OUTCTL, 32'hb);
    apb(1'b1, tcc_pkg::OFS_CCB, 32'h5);
    @(posedge clk);
    apb(1'b1, tcc_pkg::OFS_OUTCTL, 32'hf);
    shape(6, 12);
    $display("test pulse done");
  endtask : t_pulse
  task automatic t_event;
    apb(1'b1, tcc_pkg::OFS_CTRL, 32'(tcc_pkg::MODE_STOP));
    apb(1'b1, tcc_pkg::OFS_OUTCTL, 32'h0);
    apb(1'b1, tcc_pkg::OFS_PRESCALE, 32'h4);
    // trigger A is the count clock, so no clear or capture on it
    apb(1'b1, tcc_pkg::OFS_CTRL, 32'h7);
    repeat (3) tcc_pulse_src_i.pulse(1'b0, 4);
    rdc(tcc_pkg::OFS_COUNTER, 32'h1, "event count");
    // stop before the bench goes idle
    apb(1'b1, tcc_pkg::OFS_CTRL, 32'(tcc_pkg::MODE_STOP));
    rdc(tcc_pkg::OFS_COUNTER, 32'h0, "stopped before idle");
    $display("test event done");
  endtask : t_event
  task automatic results;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    mismatches = 0;
    checks = 0;
    irq_cnt = 0;
    irqb_cnt = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_count();
    t_capture();
    t_source();
    t_pulse();
    t_event();
    results();
  end
  // the tests need well under a thousand cycles; this is far beyond that
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    results();
  end
endmodule : tb_timer16_capture_compare_rules
`default_nettype wire
